// *** rtl/acs_sequencer.sv ***
/*
 converter sequencer: avalon-mm register slave, acquisition timing, bit
 period selection, conversion, abort and post-conversion wait.
 assumes the rc conversion clock and the analog comparator decision arrive
 from outside as pins, so both are synchronised before use.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int PORT_W = 13
)
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic CLK_EN,
   input wire logic [ACS_ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic PORTB_ANALOG_RESET_CFG,
   input wire logic RC_CONV_CLK,
   input wire logic CMP_DECISION,
   input wire logic [PORT_W-1:0] PORT_PINS,
   output logic [PORT_W-1:0] PORT_READ,
   output logic HOLD_CONNECT,
   output logic [ACS_RES_W-1:0] DAC_TRIAL,
   output logic CONV_DONE_IRQ_FLAG
);
   acs_state_t state;
   logic conv_module_on, conv_go_flag, result_justify_sel;
   logic [3:0] channel_sel, pin_analog_cfg;
   logic [2:0] acq_time_sel, conv_clk_sel;
   logic [15:0] result_pair;
   logic [ACS_RES_W-1:0] sar;
   logic [3:0] bit_cnt;
   logic [4:0] acq_cnt;
   logic [7:0] wait_cnt, div_cnt;
   logic rc_s1, rc_s2, rc_s3, cmp_s1, cmp_s2, strap_done;
   logic [PORT_W-1:0] pin_s1, pin_s2;
   logic req_q, period_tick, wr_go, wr_go_set;
   logic [4:0] acq_len;
   logic [7:0] div_len;

   // lookup table of acquisition lengths in bit periods
   function automatic logic [4:0] acq_periods(input logic [2:0] sel);
      case (sel)
         3'h1: acq_periods = 5'h02;
         3'h2: acq_periods = 5'h04;
         3'h3: acq_periods = 5'h06;
         3'h4: acq_periods = 5'h08;
         3'h5: acq_periods = 5'h0C;
         3'h6: acq_periods = 5'h10;
         3'h7: acq_periods = 5'h14;
         default: acq_periods = 5'h00;
      endcase
   endfunction : acq_periods

   // oscillator periods per bit period; zero means the rc clock
   function automatic logic [7:0] div_periods(input logic [2:0] sel);
      case (sel)
         3'h0: div_periods = 8'h02;
         3'h4: div_periods = 8'h04;
         3'h1: div_periods = 8'h08;
         3'h5: div_periods = 8'h10;
         3'h2: div_periods = 8'h20;
         3'h6: div_periods = 8'h40;
         default: div_periods = 8'h00;
      endcase
   endfunction : div_periods

   assign acq_len = acq_periods(acq_time_sel);
   assign div_len = div_periods(conv_clk_sel);
   assign wr_go = AVS_WRITE && req_q && AVS_ADDRESS == ACS_OFF_CTRL0 && AVS_BYTEENABLE[0];
   assign wr_go_set = wr_go && AVS_WRITEDATA[CTRL0_GO_BIT];

   // pins and the rc clock are asynchronous to MCLK
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end
      else if (CLK_EN)
      begin
         rc_s1 <= RC_CONV_CLK;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
         cmp_s1 <= CMP_DECISION;
         cmp_s2 <= cmp_s1;
         pin_s1 <= PORT_PINS;
         pin_s2 <= pin_s1;
      end
   end

   // bit-period tick from the divider or a rising edge of the rc clock
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         div_cnt <= 8'h00;
         period_tick <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (state == ACS_IDLE || state == ACS_DELAY || state == ACS_WAIT)
         begin
            div_cnt <= 8'h00;
            period_tick <= 1'b0;
         end
         else if (div_len == 8'h00)
         begin
            period_tick <= rc_s2 && !rc_s3;
         end
         else if (div_cnt == div_len - 8'h01)
         begin
            div_cnt <= 8'h00;
            period_tick <= 1'b1;
         end
         else
         begin
            div_cnt <= div_cnt + 8'h01;
            period_tick <= 1'b0;
         end
      end
   end

   // one-cycle bus answer: waitrequest drops the cycle after the request
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
         req_q <= 1'b0;
      else if (CLK_EN)
         req_q <= (AVS_READ || AVS_WRITE) && !req_q;
   end
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
         AVS_WAITREQUEST <= 1'b1;
      else if (CLK_EN)
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !req_q);
   end

   // strap caught once after release of reset
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
         strap_done <= 1'b0;
      else if (CLK_EN)
         strap_done <= 1'b1;
   end

   // control registers
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         conv_module_on <= 1'b0;
         channel_sel <= 4'h0;
         acq_time_sel <= ACS_ACQ_MANUAL;
         conv_clk_sel <= ACS_CS_RST;
         result_justify_sel <= 1'b0;
         pin_analog_cfg <= ACS_ANA_RST_ALL;
      end
      else if (CLK_EN)
      begin
         if (!strap_done)
            pin_analog_cfg <= PORTB_ANALOG_RESET_CFG ? ACS_ANA_RST_ALL
                                                     : ACS_ANA_RST_PB_DIG;
         else if (AVS_WRITE && req_q && AVS_BYTEENABLE[0])
         begin
            if (AVS_ADDRESS == ACS_OFF_CTRL0)
            begin
               conv_module_on <= AVS_WRITEDATA[CTRL0_ON_BIT];
               channel_sel <= AVS_WRITEDATA[CTRL0_CHS_LSB +: 4];
            end
            else if (AVS_ADDRESS == ACS_OFF_CTRL1)
               pin_analog_cfg <= AVS_WRITEDATA[CTRL1_ANA_LSB +: 4];
            else if (AVS_ADDRESS == ACS_OFF_TIMING)
            begin
               conv_clk_sel <= AVS_WRITEDATA[TIM_CS_LSB +: 3];
               acq_time_sel <= AVS_WRITEDATA[TIM_ACQ_LSB +: 3];
               result_justify_sel <= AVS_WRITEDATA[TIM_JUST_BIT];
            end
         end
      end
   end

   // sequencer
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         state <= ACS_IDLE;
         conv_go_flag <= 1'b0;
         acq_cnt <= 5'h00;
         bit_cnt <= 4'h0;
         wait_cnt <= 8'h00;
         sar <= '0;
      end
      else if (CLK_EN)
      begin
         case (state)
            ACS_IDLE:
            begin
               // go only takes effect while the module is already on
               if (wr_go_set && conv_module_on)
               begin
                  conv_go_flag <= 1'b1;
                  acq_cnt <= 5'h00;
                  wait_cnt <= 8'h00;
                  state <= (acq_len == 5'h00) ? ACS_DELAY : ACS_ACQ;
               end
            end
            ACS_DELAY:
            begin
               if (wr_go && !AVS_WRITEDATA[CTRL0_GO_BIT])
               begin
                  conv_go_flag <= 1'b0;
                  state <= ACS_IDLE;
               end
               else if (wait_cnt == ACS_SLEEP_OSC - 8'h01)
               begin
                  bit_cnt <= 4'h0;
                  sar <= '0;
                  state <= ACS_CONV;
               end
               else
                  wait_cnt <= wait_cnt + 8'h01;
            end
            ACS_ACQ:
            begin
               if (wr_go && !AVS_WRITEDATA[CTRL0_GO_BIT])
               begin
                  conv_go_flag <= 1'b0;
                  state <= ACS_IDLE;
               end
               else if (period_tick)
               begin
                  if (acq_cnt == acq_len - 5'h01)
                  begin
                     bit_cnt <= 4'h0;
                     sar <= '0;
                     state <= ACS_CONV;
                  end
                  else
                     acq_cnt <= acq_cnt + 5'h01;
               end
            end
            ACS_CONV:
            begin
               if ((wr_go && !AVS_WRITEDATA[CTRL0_GO_BIT]) || !conv_module_on)
               begin
                  conv_go_flag <= 1'b0;
                  wait_cnt <= 8'h00;
                  state <= ACS_WAIT;
               end
               else if (period_tick)
               begin
                  // first period settles, then one decided bit per period
                  if (bit_cnt != 4'h0)
                     sar[ACS_RES_W - 32'(bit_cnt)] <= cmp_s2;
                  if (bit_cnt == ACS_CONV_PERIODS - 4'h1)
                  begin
                     conv_go_flag <= 1'b0;
                     wait_cnt <= 8'h00;
                     state <= ACS_WAIT;
                  end
                  else
                     bit_cnt <= bit_cnt + 4'h1;
               end
            end
            ACS_WAIT:
            begin
               if (wait_cnt == ACS_POST_OSC - 8'h01)
                  state <= ACS_IDLE;
               else
                  wait_cnt <= wait_cnt + 8'h01;
            end
            default: state <= ACS_IDLE;
         endcase
      end
   end

   // result write shares the completing edge with go and done
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
         result_pair <= 16'h0000;
      else if (CLK_EN)
      begin
         if (state == ACS_CONV && period_tick && bit_cnt == ACS_CONV_PERIODS - 4'h1
             && conv_module_on && !(wr_go && !AVS_WRITEDATA[CTRL0_GO_BIT]))
            result_pair <= result_justify_sel
                           ? {6'h00, sar[ACS_RES_W-1:1], cmp_s2}
                           : {sar[ACS_RES_W-1:1], cmp_s2, 6'h00};
         else if (AVS_WRITE && req_q && AVS_ADDRESS == ACS_OFF_RESULT)
         begin
            if (AVS_BYTEENABLE[0])
               result_pair[7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1])
               result_pair[15:8] <= AVS_WRITEDATA[15:8];
         end
      end
   end

   // done flag: set wins over a software clear in the same cycle unless that write also clears go
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
         CONV_DONE_IRQ_FLAG <= 1'b0;
      else if (CLK_EN)
      begin
         if (state == ACS_CONV && period_tick && bit_cnt == ACS_CONV_PERIODS - 4'h1
             && conv_module_on && !(wr_go && !AVS_WRITEDATA[CTRL0_GO_BIT]))
            CONV_DONE_IRQ_FLAG <= 1'b1;
         else if (wr_go && AVS_WRITEDATA[CTRL0_DONE_BIT] && AVS_BYTEENABLE[1])
            CONV_DONE_IRQ_FLAG <= 1'b0;
      end
   end

   // analog-side outputs; conversion ignores channel and direction
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         HOLD_CONNECT <= 1'b0;
         DAC_TRIAL <= '0;
         PORT_READ <= '0;
      end
      else if (CLK_EN)
      begin
         HOLD_CONNECT <= conv_module_on && !(state == ACS_CONV) && !(state == ACS_WAIT);
         DAC_TRIAL <= sar | ((state == ACS_CONV && bit_cnt != 4'h0 && bit_cnt < ACS_CONV_PERIODS)
                      ? ACS_RES_W'(1) << (ACS_RES_W - 32'(bit_cnt)) : '0);
         // digital pins are the top (code - 2) pins; codes up to 2 leave every pin analog
         for (int i = 0; i < PORT_W; i++)
            PORT_READ[i] <= (32'(i) + 32'(pin_analog_cfg) >= 32'(PORT_W) + 32'h2)
                            ? pin_s2[i] : 1'b0;
      end
   end

   // read data
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
         AVS_READDATA <= 32'h0000_0000;
      else if (CLK_EN)
      begin
         if (AVS_ADDRESS == ACS_OFF_CTRL0)
            AVS_READDATA <= 32'({state != ACS_IDLE && state != ACS_WAIT, CONV_DONE_IRQ_FLAG,
                            2'h0, channel_sel, conv_go_flag, conv_module_on});
         else if (AVS_ADDRESS == ACS_OFF_CTRL1)
            AVS_READDATA <= 32'(pin_analog_cfg);
         else if (AVS_ADDRESS == ACS_OFF_TIMING)
            AVS_READDATA <= 32'({result_justify_sel, 1'b0, acq_time_sel, conv_clk_sel});
         else
            AVS_READDATA <= 32'(result_pair);
      end
   end

   AST_GO_CLEARS_WITH_DONE: assert property (@(posedge MCLK) disable iff (!RST_B)
      $rose(CONV_DONE_IRQ_FLAG) |-> $fell(conv_go_flag))
      else $error("done set without go clearing");
   AST_RESET_MANUAL: assert property (@(posedge MCLK)
      !RST_B |=> acq_time_sel == ACS_ACQ_MANUAL && !conv_module_on)
      else $error("reset left acquisition or module state");
   AST_WAIT_LEN: assert property (@(posedge MCLK) disable iff (!RST_B || !CLK_EN)
      $rose(state == ACS_WAIT) |-> (state == ACS_WAIT) [*8] ##1 state == ACS_IDLE)
      else $error("post wait not two instruction cycles");
   AST_HOLD_OFF: assert property (@(posedge MCLK) disable iff (!RST_B)
      state == ACS_CONV |=> !HOLD_CONNECT)
      else $error("hold capacitor still connected");
   AST_DELAY_ONE_TCY: assert property (@(posedge MCLK) disable iff (!RST_B || !CLK_EN)
      $rose(state == ACS_DELAY) && conv_go_flag |-> (state == ACS_DELAY) [*4])
      else $error("manual start delay wrong");
   AST_GO_HELD: assert property (@(posedge MCLK) disable iff (!RST_B)
      state == ACS_ACQ |-> conv_go_flag)
      else $error("go dropped during acquisition");
   AST_ABORT_KEEPS: assert property (@(posedge MCLK) disable iff (!RST_B)
      $past(state) == ACS_CONV && $fell(conv_go_flag) && !$rose(CONV_DONE_IRQ_FLAG)
      |-> $stable(result_pair))
      else $error("abort changed result");
   AST_MANUAL_NO_ACQ: assert property (@(posedge MCLK) disable iff (!RST_B)
      $past(state) == ACS_IDLE && state != ACS_IDLE && acq_time_sel == 3'h0
      |-> state == ACS_DELAY)
      else $error("manual mode entered acquisition");
   COV_DONE: cover property (@(posedge MCLK) $rose(CONV_DONE_IRQ_FLAG));
   COV_ABORT: cover property (@(posedge MCLK) state == ACS_CONV ##1 state == ACS_WAIT
      && !CONV_DONE_IRQ_FLAG);
   COV_PROG_ACQ: cover property (@(posedge MCLK) state == ACS_ACQ ##1 state == ACS_CONV);
endmodule : acs_sequencer
`default_nettype wire

// *** rtl/acs_pkg.sv ***
/*
 holds the register map, field layout, encodings, reset values and timing
 counts of the converter sequencer. assumes a 250 MHz system clock.
*/
package acs_pkg;
   localparam int ACS_ADDR_W = 4;
   localparam logic [3:0] ACS_OFF_CTRL0 = 4'h0;
   localparam logic [3:0] ACS_OFF_CTRL1 = 4'h4;
   localparam logic [3:0] ACS_OFF_TIMING = 4'h8;
   localparam logic [3:0] ACS_OFF_RESULT = 4'hC;
   localparam int CTRL0_ON_BIT = 0;
   localparam int CTRL0_GO_BIT = 1;
   localparam int CTRL0_CHS_LSB = 2;
   localparam int CTRL0_DONE_BIT = 8;
   localparam int CTRL0_SAMPLING_BIT = 9;
   localparam int CTRL1_ANA_LSB = 0;
   localparam int TIM_CS_LSB = 0;
   localparam int TIM_ACQ_LSB = 3;
   localparam int TIM_JUST_BIT = 7;
   localparam logic [2:0] ACS_ACQ_MANUAL = 3'h0;
   localparam logic [3:0] ACS_ANA_RST_ALL = 4'h0;
   localparam logic [3:0] ACS_ANA_RST_PB_DIG = 4'h7;
   localparam logic [2:0] ACS_CS_RST = 3'h0;
   localparam logic [3:0] ACS_CONV_PERIODS = 4'hB;
   localparam int ACS_RES_W = 10;
   localparam int ACS_TCY_OSC = 4;
   localparam logic [2:0] ACS_POST_TCY = 3'h2;
   localparam logic [7:0] ACS_POST_OSC = 8'(ACS_POST_TCY * ACS_TCY_OSC);
   localparam logic [7:0] ACS_SLEEP_OSC = 8'(ACS_TCY_OSC);
   typedef enum logic [4:0] {
      ACS_IDLE = 5'h01,
      ACS_DELAY = 5'h02,
      ACS_ACQ = 5'h04,
      ACS_CONV = 5'h08,
      ACS_WAIT = 5'h10
   } acs_state_t;
endpackage : acs_pkg

// *** testbench/acs_sequencer_tb.sv ***
/*
 self-checking bench for the converter sequencer: avalon-mm read and write
 tasks, conversion timing per clock and acquisition code, abort, post wait,
 port masking and strap-driven reset. assumes the comparator input held high
 gives an all-ones result and that the rc clock pin may run freely.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
   import acs_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic strap = 1'b1;
   logic rc_clk = 1'b0;
   logic [1:0] rc_div = 2'h0;
   logic clk_en = 1'b1;
   logic [12:0] pins = 13'h1FFF;
   logic [12:0] port_read;
   logic hold_connect;
   logic [9:0] dac_trial;
   logic done_flag;
   int error_cnt = 0;
   int checks = 0;
   logic [31:0] rd;
   int cyc;
   int div_tab[6] = '{2, 4, 8, 16, 32, 64};
   logic [2:0] sel_tab[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
   int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

   always #2 mclk = ~mclk;
   // rc pin modelled as a clock of four mclk periods; the design still synchronises it
   always @(posedge mclk)
   begin
      rc_div <= rc_div + 2'h1;
      rc_clk <= rc_div[1];
   end

   acs_sequencer #(.PORT_W(13)) acs_sequencer_i (
      .MCLK(mclk), .RST_B(rst_b), .CLK_EN(clk_en),
      .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
      .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest),
      .PORTB_ANALOG_RESET_CFG(strap), .RC_CONV_CLK(rc_clk),
      .CMP_DECISION(1'b1), .PORT_PINS(pins), .PORT_READ(port_read),
      .HOLD_CONNECT(hold_connect), .DAC_TRIAL(dac_trial),
      .CONV_DONE_IRQ_FLAG(done_flag)
   );

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // cycle counts are bench values, so plain ints suffice here
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   task automatic bus_cycle(input logic [3:0] a, input logic wr, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      @(posedge mclk);
      while (waitrequest !== 1'b0 && n < 100)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 100)
         chk("bus answer", 32'h0, 32'h1);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      // one idle edge, so a following call never reassigns the strobe in this step
      @(posedge mclk);
   endtask : bus_cycle

   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      bus_cycle(a, 1'b1, d);
   endtask : bus_write

   task automatic bus_read(input logic [3:0] a);
      bus_cycle(a, 1'b0, 32'h0);
   endtask : bus_read

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask : do_reset

   // starts one conversion, counts cycles to done, then the wait before resampling
   task automatic run_conv(input logic [7:0] timing, input int lo, input int hi);
      int n;
      bus_write(ACS_OFF_TIMING, {24'h0, timing});
      bus_write(ACS_OFF_CTRL0, 32'h101);
      repeat (12) @(posedge mclk);
      bus_write(ACS_OFF_CTRL0, 32'h003);
      cyc = 0;
      while (done_flag !== 1'b1 && cyc < 5000)
      begin
         @(posedge mclk);
         cyc++;
      end
      chk_rng("conversion cycles", lo, hi, cyc);
      n = 0;
      while (hold_connect !== 1'b1 && n < 100)
      begin
         @(posedge mclk);
         n++;
      end
      chk_rng("post wait cycles", 7, 10, n);
      bus_read(ACS_OFF_CTRL0);
      chk("ctrl0 after done", 32'h101, rd & 32'h303);
      chk("dac trial after done", 32'h3FF, {22'h0, dac_trial});
   endtask : run_conv

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      $display("Error watchdog expected finish seen timeout");
      give_verdict();
   end

   initial
   begin
      do_reset();
      bus_read(ACS_OFF_CTRL1);
      chk("analog cfg reset", 32'h0, rd & 32'hF);
      bus_read(ACS_OFF_TIMING);
      chk("timing reset", 32'h0, rd & 32'hFF);
      bus_read(ACS_OFF_CTRL0);
      chk("ctrl0 reset", 32'h0, rd & 32'h303);
      $display("test reset done");

      // go with the module off must not start anything
      bus_write(ACS_OFF_CTRL0, 32'h002);
      repeat (40) @(posedge mclk);
      chk("done with module off", 32'h0, {31'h0, done_flag});

      // module on alone, then 2 us before the first go
      bus_write(ACS_OFF_CTRL0, 32'h001);
      repeat (500) @(posedge mclk);
      for (int i = 0; i < 6; i++)
         run_conv({1'b1, 4'h0, sel_tab[i]}, 3 + 11 * div_tab[i], 8 + 12 * div_tab[i]);
      bus_read(ACS_OFF_RESULT);
      chk("right justified", 32'h3FF, rd & 32'hFFFF);
      for (int a = 1; a < 8; a++)
         run_conv({1'b0, 1'b0, 3'(a), 3'h0}, (acq_tab[a] + 11) * 2 - 1, (acq_tab[a] + 12) * 2 + 6);
      bus_read(ACS_OFF_RESULT);
      chk("left justified", 32'hFFC0, rd & 32'hFFFF);
      run_conv(8'h83, 20, 600);
      $display("test timing done");

      // abort during conversion keeps the value software wrote
      bus_write(ACS_OFF_RESULT, 32'h155);
      bus_write(ACS_OFF_TIMING, 32'hBE);
      bus_write(ACS_OFF_CTRL0, 32'h101);
      repeat (12) @(posedge mclk);
      bus_write(ACS_OFF_CTRL0, 32'h003);
      repeat (100) @(posedge mclk);
      chk("sampling during acq", 32'h1, {31'h0, hold_connect});
      bus_read(ACS_OFF_CTRL0);
      chk("go held in acq", 32'h2, rd & 32'h2);
      repeat (1400) @(posedge mclk);
      chk("hold open in conv", 32'h0, {31'h0, hold_connect});
      bus_write(ACS_OFF_CTRL0, 32'h001);
      repeat (30) @(posedge mclk);
      bus_read(ACS_OFF_CTRL0);
      chk("ctrl0 after abort", 32'h001, rd & 32'h303);
      bus_read(ACS_OFF_RESULT);
      chk("result after abort", 32'h155, rd & 32'hFFFF);
      chk("resampling after abort", 32'h1, {31'h0, hold_connect});
      $display("test abort done");

      bus_write(ACS_OFF_CTRL1, 32'h7);
      repeat (6) @(posedge mclk);
      chk("port read cfg 7", 32'h1F00, {19'h0, port_read});
      bus_write(ACS_OFF_CTRL1, 32'h0);
      repeat (6) @(posedge mclk);
      chk("port read all analog", 32'h0, {19'h0, port_read});
      bus_write(ACS_OFF_CTRL1, 32'hF);
      repeat (6) @(posedge mclk);
      chk("port read all digital", 32'h1FFF, {19'h0, port_read});
      // clock enable low must freeze the pin path as well
      clk_en <= 1'b0;
      pins <= 13'h0000;
      repeat (6) @(posedge mclk);
      chk("port read frozen", 32'h1FFF, {19'h0, port_read});
      clk_en <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("port read live", 32'h0, {19'h0, port_read});
      $display("test port done");

      // reset in mid-run with the strap low
      bus_write(ACS_OFF_CTRL0, 32'h003);
      strap <= 1'b0;
      repeat (10) @(posedge mclk);
      do_reset();
      bus_read(ACS_OFF_CTRL1);
      chk("analog cfg strap low", 32'h7, rd & 32'hF);
      bus_read(ACS_OFF_CTRL0);
      chk("ctrl0 after reset", 32'h0, rd & 32'h303);
      $display("test second reset done");
      give_verdict();
   end
endmodule : acs_sequencer_tb
`default_nettype wire
